// ---- inc/aux_timer_defines.svh ----
// Contract
// - Count on aux pin or latch edges
// - Edge select: x00 off, pin or latch edges
// - Only overflow latch toggles count, not software
// - Both latch edges: step per overflow
// - One latch edge: step every second overflow
// - Aux direction independent of core timer
// - Mode 100 reload, trigger by edge select
// - Reload mode stops counting regardless run
// - Trigger copies aux value, sets aux flag
// - Latch triggered reload also sets core flag
// - Software latch writes never cause reload
// - Both edges reload each overflow, else second
// - Rise/fall split gives alternating PWM reload
// - Latch drives output only when enabled
// - Same trigger: second aux timer wins
// - Mode 101 captures core value on pin
// - Capture uses low two select bits only
// - Capture sets aux flag same cycle
`ifndef AUX_TIMER_DEFINES_SVH
`define AUX_TIMER_DEFINES_SVH

// ----------------------------------------
// Field values and reset values
// ----------------------------------------
`define AUX_MODE_COUNTER 3'h1
`define AUX_MODE_RELOAD 3'h4
`define AUX_MODE_CAPTURE 3'h5
`define AUX_SEL_SRC_BIT 2
`define AUX_SEL_NONE 2'h0
`define AUX_SEL_RISE 2'h1
`define AUX_SEL_FALL 2'h2
`define AUX_SEL_ANY 2'h3
`define AUX_TIMER_RESET 16'h0000
`define AUX_SYNC_DEPTH 3

`endif

// ---- inc/aux_timer_pkg.sv ----
package aux_timer_pkg;

	// ----------------------------------------
	// Per-timer control fields
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] edge_sel;
		logic run;
		logic count_down;
	} aux_cfg_t;

	// ----------------------------------------
	// Register state of the block except the reset synchronizer
	// ----------------------------------------
	typedef struct packed {
		logic [1:0][2:0] pin_sync;
		logic [1:0] pin_filt;
		logic [1:0][15:0] timer;
		logic reload;
		logic [15:0] reload_val;
		logic core_irq;
		logic [1:0] aux_irq;
		logic toggle_out;
	} aux_state_t;

endpackage

// ---- core/aux_timer_counter_reload_capture.sv ----
`timescale 1ns/1ps
`include "aux_timer_defines.svh"

module aux_timer_counter_reload_capture (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire aux_timer_pkg::aux_cfg_t aux_a_cfg_in,
	input wire aux_timer_pkg::aux_cfg_t aux_b_cfg_in,
	input wire logic aux_a_wr_in,
	input wire logic [15:0] aux_a_wr_data_in,
	input wire logic aux_b_wr_in,
	input wire logic [15:0] aux_b_wr_data_in,
	input wire logic aux_a_count_input_in,
	input wire logic aux_b_count_input_in,
	input wire logic [15:0] core_timer_value_in,
	input wire logic core_ovf_in,
	input wire logic core_overflow_toggle_latch_in,
	input wire logic core_output_enable_in,
	output logic [15:0] aux_a_value_out,
	output logic [15:0] aux_b_value_out,
	output logic core_reload_out,
	output logic [15:0] core_reload_value_out,
	output logic core_irq_set_out,
	output logic aux_a_irq_set_out,
	output logic aux_b_irq_set_out,
	output logic core_toggle_output_out
);
	import aux_timer_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (sel)
			`AUX_SEL_RISE: hit = rise;
			`AUX_SEL_FALL: hit = fall;
			`AUX_SEL_ANY: hit = rise | fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Plain 16-bit arithmetic wraps in both directions
	function automatic logic [15:0] step(input logic [15:0] v, input logic down);
		return down ? v - 16'h1 : v + 16'h1;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	aux_state_t s_q;
	aux_state_t s_d;
	aux_cfg_t [1:0] cfg;
	logic [1:0] pin;
	logic [1:0] wr;
	logic [1:0][15:0] wr_data;

	assign cfg = {aux_b_cfg_in, aux_a_cfg_in};
	assign pin = {aux_b_count_input_in, aux_a_count_input_in};
	assign wr = {aux_b_wr_in, aux_a_wr_in};
	assign wr_data = {aux_b_wr_data_in, aux_a_wr_data_in};

	always_comb begin
		logic otl_rise;
		logic otl_fall;
		logic p_rise;
		logic p_fall;
		logic src_rise;
		logic src_fall;
		logic hit;
		logic a_reload;
		otl_rise = 1'b0;
		otl_fall = 1'b0;
		p_rise = 1'b0;
		p_fall = 1'b0;
		src_rise = 1'b0;
		src_fall = 1'b0;
		hit = 1'b0;
		a_reload = 1'b0;
		s_d = s_q;
		s_d.reload = 1'b0;
		s_d.core_irq = 1'b0;
		s_d.aux_irq = 2'h0;
		s_d.toggle_out = core_output_enable_in & core_overflow_toggle_latch_in;
		// Latch edges are taken from the overflow pulse, so writes by software are invisible
		otl_rise = core_ovf_in & ~core_overflow_toggle_latch_in;
		otl_fall = core_ovf_in & core_overflow_toggle_latch_in;
		for (int i = 0; i < 2; i++) begin
			// A level is accepted once stages two and three agree; needs slow pins
			s_d.pin_sync[i] = {s_q.pin_sync[i][1:0], pin[i]};
			if (s_q.pin_sync[i][1] == s_q.pin_sync[i][2]) begin
				s_d.pin_filt[i] = s_q.pin_sync[i][2];
			end
			p_rise = s_d.pin_filt[i] & ~s_q.pin_filt[i];
			p_fall = ~s_d.pin_filt[i] & s_q.pin_filt[i];
			src_rise = cfg[i].edge_sel[`AUX_SEL_SRC_BIT] ? otl_rise : p_rise;
			src_fall = cfg[i].edge_sel[`AUX_SEL_SRC_BIT] ? otl_fall : p_fall;
			// x00 returns no hit; one latch edge halves the rate
			hit = edge_hit(cfg[i].edge_sel[1:0], src_rise, src_fall);
			if (wr[i]) begin
				s_d.timer[i] = wr_data[i];
			end
			case (cfg[i].mode)
				`AUX_MODE_COUNTER: begin
					if (cfg[i].run && hit) begin
						s_d.timer[i] = step(s_q.timer[i], cfg[i].count_down);
					end
				end
				`AUX_MODE_RELOAD: begin
					// No counting here whatever run says
					if (hit) begin
						s_d.reload = 1'b1;
						s_d.reload_val = s_q.timer[i];
						// Second timer runs last, so it overrides the first
						s_d.aux_irq[i] = 1'b1;
						if (i == 1) begin
							// Only a reload flag of the first is dropped; its capture flag stays
							s_d.aux_irq[0] = s_d.aux_irq[0] & ~a_reload;
						end else begin
							a_reload = 1'b1;
						end
						if (cfg[i].edge_sel[`AUX_SEL_SRC_BIT]) begin
							s_d.core_irq = 1'b1;
						end
					end
				end
				`AUX_MODE_CAPTURE: begin
					if (edge_hit(cfg[i].edge_sel[1:0], p_rise, p_fall)) begin
						s_d.timer[i] = core_timer_value_in;
						s_d.aux_irq[i] = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.timer <= {`AUX_TIMER_RESET, `AUX_TIMER_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	assign aux_a_value_out = s_q.timer[0];
	assign aux_b_value_out = s_q.timer[1];
	assign core_reload_out = s_q.reload;
	assign core_reload_value_out = s_q.reload_val;
	assign core_irq_set_out = s_q.core_irq;
	assign aux_a_irq_set_out = s_q.aux_irq[0];
	assign aux_b_irq_set_out = s_q.aux_irq[1];
	assign core_toggle_output_out = s_q.toggle_out;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n);

	a_count_otl_both: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.run && aux_a_cfg_in.edge_sel == 3'h7
			&& !aux_a_cfg_in.count_down && !aux_a_wr_in && core_ovf_in)
		|=> aux_a_value_out == $past(aux_a_value_out) + 16'h1)
		else $error("aux a missed latch step");

	a_sw_latch_quiet: assert property (
		(!core_ovf_in && aux_a_cfg_in.edge_sel[2] && aux_b_cfg_in.edge_sel[2]) |=> !core_irq_set_out)
		else $error("reload without overflow");

	a_reload_no_count: assert property (
		(aux_b_cfg_in.mode == `AUX_MODE_RELOAD && !aux_b_wr_in) |=> $stable(aux_b_value_out))
		else $error("aux b moved in reload mode");

	// A capture on one timer may coincide with a reload from the other
	a_reload_flags: assert property (
		core_reload_out |-> (aux_a_irq_set_out || aux_b_irq_set_out))
		else $error("reload without aux flag");

	a_reload_b_wins: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_RELOAD && aux_b_cfg_in.mode == `AUX_MODE_RELOAD
			&& aux_a_cfg_in.edge_sel == 3'h7 && aux_b_cfg_in.edge_sel == 3'h7 && core_ovf_in)
		|=> core_reload_value_out == $past(aux_b_value_out) && !aux_a_irq_set_out)
		else $error("aux b did not win reload");

	a_core_irq_cause: assert property (
		core_irq_set_out |-> $past(core_ovf_in) && core_reload_out)
		else $error("core flag without overflow");

	a_capture_value: assert property (
		($past(aux_a_cfg_in.mode) == `AUX_MODE_CAPTURE && aux_a_irq_set_out)
		|-> aux_a_value_out == $past(core_timer_value_in))
		else $error("capture stored wrong value");

	a_output_gate: assert property (
		!core_output_enable_in |=> !core_toggle_output_out)
		else $error("toggle output not gated");

	a_count_disabled: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.edge_sel[1:0] == 2'h0
			&& !aux_a_wr_in) |=> $stable(aux_a_value_out))
		else $error("aux a counted while disabled");

	// ----------------------------------------
	// Counter checks
	// ----------------------------------------
	a_count_otl_down: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.run && aux_a_cfg_in.edge_sel == 3'h7
			&& aux_a_cfg_in.count_down && !aux_a_wr_in && core_ovf_in)
		|=> aux_a_value_out == $past(aux_a_value_out) - 16'h1)
		else $error("aux a missed down step");

	a_count_wrap_up: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.run && aux_a_cfg_in.edge_sel == 3'h7
			&& !aux_a_cfg_in.count_down && !aux_a_wr_in && core_ovf_in
			&& aux_a_value_out == 16'hFFFF)
		|=> aux_a_value_out == 16'h0000)
		else $error("aux a did not wrap");

	// Single latch edge: the other overflow must leave the timer alone
	a_count_half_skip: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.run && aux_a_cfg_in.edge_sel == 3'h5
			&& !aux_a_wr_in && core_ovf_in && core_overflow_toggle_latch_in)
		|=> $stable(aux_a_value_out))
		else $error("aux a stepped on wrong latch edge");

	a_count_half_step: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.run && aux_a_cfg_in.edge_sel == 3'h5
			&& !aux_a_cfg_in.count_down && !aux_a_wr_in && core_ovf_in
			&& !core_overflow_toggle_latch_in)
		|=> aux_a_value_out == $past(aux_a_value_out) + 16'h1)
		else $error("aux a missed rising latch step");

	// Software toggles of the latch come without an overflow pulse
	a_count_sw_quiet: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_COUNTER && aux_a_cfg_in.edge_sel[2]
			&& !core_ovf_in && !aux_a_wr_in)
		|=> $stable(aux_a_value_out))
		else $error("aux a counted without overflow");

	// ----------------------------------------
	// Reload checks
	// ----------------------------------------
	a_reload_a_quiet: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_RELOAD && !aux_a_wr_in) |=> $stable(aux_a_value_out))
		else $error("aux a moved in reload mode");

	a_reload_core_flag: assert property (
		(aux_b_cfg_in.mode == `AUX_MODE_RELOAD && aux_b_cfg_in.edge_sel == 3'h7 && core_ovf_in)
		|=> core_reload_out && core_irq_set_out && aux_b_irq_set_out
			&& core_reload_value_out == $past(aux_b_value_out))
		else $error("latch reload incomplete");

	a_reload_b_flag: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_RELOAD && aux_b_cfg_in.mode == `AUX_MODE_RELOAD
			&& aux_a_cfg_in.edge_sel == 3'h7 && aux_b_cfg_in.edge_sel == 3'h7 && core_ovf_in)
		|=> aux_b_irq_set_out)
		else $error("aux b flag missing on shared trigger");

	a_pwm_high: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_RELOAD && aux_b_cfg_in.mode == `AUX_MODE_RELOAD
			&& aux_a_cfg_in.edge_sel == 3'h5 && aux_b_cfg_in.edge_sel == 3'h6 && core_ovf_in
			&& !core_overflow_toggle_latch_in)
		|=> core_reload_value_out == $past(aux_a_value_out) && aux_a_irq_set_out)
		else $error("rising latch did not reload from aux a");

	a_pwm_low: assert property (
		(aux_a_cfg_in.mode == `AUX_MODE_RELOAD && aux_b_cfg_in.mode == `AUX_MODE_RELOAD
			&& aux_a_cfg_in.edge_sel == 3'h5 && aux_b_cfg_in.edge_sel == 3'h6 && core_ovf_in
			&& core_overflow_toggle_latch_in)
		|=> core_reload_value_out == $past(aux_b_value_out) && aux_b_irq_set_out)
		else $error("falling latch did not reload from aux b");

	// Reload value is only meaningful with the pulse, but is kept steady for the core side
	a_reload_value_hold: assert property (
		!core_reload_out |-> $stable(core_reload_value_out))
		else $error("reload value moved without reload");

	// ----------------------------------------
	// Flag and output checks
	// ----------------------------------------
	a_capture_flag: assert property (
		($past(aux_a_cfg_in.mode) == `AUX_MODE_CAPTURE && !$past(aux_a_wr_in)
			&& $changed(aux_a_value_out))
		|-> aux_a_irq_set_out)
		else $error("capture without aux a flag");

	a_aux_a_irq_cause: assert property (
		aux_a_irq_set_out |-> ($past(aux_a_cfg_in.mode) == `AUX_MODE_RELOAD
			|| $past(aux_a_cfg_in.mode) == `AUX_MODE_CAPTURE))
		else $error("aux a flag in wrong mode");

	a_aux_b_irq_cause: assert property (
		aux_b_irq_set_out |-> ($past(aux_b_cfg_in.mode) == `AUX_MODE_RELOAD
			|| $past(aux_b_cfg_in.mode) == `AUX_MODE_CAPTURE))
		else $error("aux b flag in wrong mode");

	a_output_follow: assert property (
		core_output_enable_in |=> core_toggle_output_out == $past(core_overflow_toggle_latch_in))
		else $error("toggle output does not follow latch");

endmodule

// ---- verification/core_timer_model.sv ----
`timescale 1ns/1ps

module core_timer_model (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic run_in,
	input wire logic sw_toggle_in,
	input wire logic reload_in,
	input wire logic [15:0] reload_value_in,
	output logic [15:0] value_out,
	output logic ovf_out,
	output logic latch_out
);
	// ----------------------------------------
	// Core timer seen from the aux block
	// ----------------------------------------
	// Starts near all ones so overflows come quickly
	assign ovf_out = run_in && (value_out == 16'hFFFF);
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			value_out <= 16'hFFF0;
			latch_out <= 1'b0;
		end else begin
			if (reload_in) begin
				value_out <= reload_value_in;
			end else if (run_in) begin
				value_out <= value_out + 16'h0001;
			end
			// Software flips move the latch with no overflow pulse
			latch_out <= latch_out ^ ovf_out ^ sw_toggle_in;
		end
	end
endmodule

// ---- verification/tb_aux_timer_counter_reload_capture.sv ----
`timescale 1ns/1ps
`include "aux_timer_defines.svh"

module tb_aux_timer_counter_reload_capture;
	import aux_timer_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, a_wr = 1'b0, b_wr = 1'b0, pa = 1'b0, pb = 1'b0;
	logic run = 1'b0, sw = 1'b0, oe = 1'b0, seen = 1'b0, rise = 1'b0, po = 1'b0, dn, cap;
	aux_cfg_t ca = '0, cb = '0;
	logic [15:0] wd = 16'h0000, ea, eb, cv, a_v, b_v, rv;
	logic ovf, lat, rl, ci, ai, bi, tout;
	int n_fail = 0, n_tests = 0, lr = 0, lf = 0, k, n;

	always #25 clk = ~clk;
	aux_timer_counter_reload_capture u_dut (.mclk_in(clk), .reset_n_in(rst_n),
		.aux_a_cfg_in(ca), .aux_b_cfg_in(cb), .aux_a_wr_in(a_wr), .aux_a_wr_data_in(wd),
		.aux_b_wr_in(b_wr), .aux_b_wr_data_in(wd), .aux_a_count_input_in(pa),
		.aux_b_count_input_in(pb), .core_timer_value_in(cv), .core_ovf_in(ovf),
		.core_overflow_toggle_latch_in(lat), .core_output_enable_in(oe), .aux_a_value_out(a_v),
		.aux_b_value_out(b_v), .core_reload_out(rl), .core_reload_value_out(rv),
		.core_irq_set_out(ci), .aux_a_irq_set_out(ai), .aux_b_irq_set_out(bi),
		.core_toggle_output_out(tout));
	core_timer_model u_core (.mclk_in(clk), .reset_n_in(rst_n), .run_in(run), .sw_toggle_in(sw),
		.reload_in(rl), .reload_value_in(rv), .value_out(cv), .ovf_out(ovf), .latch_out(lat));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic hit(input aux_cfg_t c, input logic r);
		return c.mode == `AUX_MODE_RELOAD && c.edge_sel[2] && (r ? c.edge_sel[0] : c.edge_sel[1]);
	endfunction
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic b, input logic [15:0] v);
		wd = v;
		a_wr = !b;
		b_wr = b;
		cyc(1);
		a_wr = 1'b0;
		b_wr = 1'b0;
	endtask
	task automatic give_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Reload and output monitor
	// ----------------------------------------
	// Sampled on the falling edge so registered outputs have settled
	always @(negedge clk) begin
		if (seen) begin
			chk({15'h0000, rl}, {15'h0000, hit(ca, rise) | hit(cb, rise)});
			chk({15'h0000, ci}, {15'h0000, hit(ca, rise) | hit(cb, rise)});
			chk({15'h0000, bi}, {15'h0000, hit(cb, rise)});
			chk({15'h0000, ai}, {15'h0000, hit(ca, rise) & !hit(cb, rise)});
			if (rl === 1'b1) chk(rv, hit(cb, rise) ? eb : ea);
		end
		if (rst_n) chk({15'h0000, tout}, {15'h0000, po});
		po <= oe & lat;
		seen <= ovf;
		rise <= !lat;
		if (ovf && lat) lf++;
		if (ovf && !lat) lr++;
	end

	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end

	initial begin
		void'($urandom(32'h6EC97CE4));
		cyc(16);
		rst_n = 1'b1;
		cyc(3);
		eb = 16'hFFF8;
		wr(1'b1, eb);
		cb = '{`AUX_MODE_RELOAD, 3'h7, 1'b1, 1'b0};
		// Every edge select code, pin and latch sources, direction picked at random per code
		for (int s = 0; s < 8; s++) begin
			dn = 1'($urandom);
			ca = '{`AUX_MODE_COUNTER, s[2:0], 1'b1, dn};
			wr(1'b0, dn ? 16'h0002 : 16'hFFFD);
			lr = 0;
			lf = 0;
			run = 1'b1;
			oe = 1'($urandom);
			k = 1 + $urandom % 6;
			repeat (k) begin
				pa = 1'b1;
				cyc(6);
				pa = 1'b0;
				cyc(6);
			end
			sw = 1'b1;
			cyc(1);
			sw = 1'b0;
			run = 1'b0;
			cyc(8);
			n = s[2] ? (s[0] ? lr : 0) + (s[1] ? lf : 0) : (s[0] ? k : 0) + (s[1] ? k : 0);
			ea = dn ? wd - 16'(n) : wd + 16'(n);
			chk(a_v, ea);
			$display("counter select %0d done", s);
		end
		// Reload mode must not count even with run set
		ca = '{`AUX_MODE_RELOAD, 3'h0, 1'b1, 1'b0};
		pa = 1'b1;
		cyc(6);
		pa = 1'b0;
		cyc(6);
		chk(a_v, ea);
		for (int r = 0; r < 3; r++) begin
			ea = 16'hFFF0 + 16'($urandom % 8);
			wr(1'b0, ea);
			ca = '{`AUX_MODE_RELOAD, r == 0 ? 3'h5 : (r == 1 ? 3'h7 : 3'h6), 1'b1, 1'b0};
			cb = '{`AUX_MODE_RELOAD, r == 0 ? 3'h6 : (r == 1 ? 3'h7 : 3'h5), 1'b1, 1'b0};
			cyc(2);
			run = 1'b1;
			cyc(60);
			run = 1'b0;
			cyc(4);
			$display("reload pairing %0d done", r);
		end
		for (int lo = 1; lo < 4; lo++) begin
			ca = '{`AUX_MODE_CAPTURE, {1'($urandom), 2'(lo)}, 1'b1, 1'b0};
			for (int e = 0; e < 2; e++) begin
				run = 1'b1;
				cyc(1 + $urandom % 5);
				run = 1'b0;
				cyc(2);
				pa = !pa;
				cap = pa ? lo[0] : lo[1];
				ea = cap ? cv : a_v;
				cyc(3);
				@(posedge clk);
				#1;
				chk(a_v, ea);
				chk({15'h0000, ai}, {15'h0000, cap});
			end
			$display("capture select %0d done", lo);
		end
		give_verdict();
	end
endmodule
